// File: core/adr_pkg.sv
// Shared constants and types for the absolute data readout block
package adr_pkg;
	// Core clock rate and time figures
	localparam int unsigned CLK_KHZ = 250000;
	localparam int unsigned CLR_HOLD_MS = 120;
	localparam int unsigned READY_DELAY_MS = 2000;
	localparam int unsigned CLR_HOLD_CYC = CLR_HOLD_MS * CLK_KHZ;
	localparam int unsigned READY_DELAY_CYC = READY_DELAY_MS * CLK_KHZ;
	// Record layout
	localparam int unsigned REC_LEN = 15;
	localparam logic [3:0] IDX_LAST = 4'hE;
	localparam logic [3:0] IDX_FIRST = 4'h0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [3:0] RECOG_HIGH = 4'h8;
	localparam logic [3:0] AXIS_HOST = 4'h0;
	// Command codes of the host request
	localparam logic [3:0] CMD_ABS_READ = 4'hB;
	// Encoder status low byte bit positions
	localparam int unsigned STAT_BATT_ALARM = 0;
	localparam int unsigned STAT_MT_ERR = 1;
	localparam int unsigned STAT_OVF = 2;
	localparam int unsigned STAT_CNT_ERR = 3;
	localparam int unsigned STAT_FULL_ABS = 4;
	localparam int unsigned STAT_SUMMARY = 5;

	typedef enum logic [1:0] {
		ADR_TOPO_232 = 2'h0,
		ADR_TOPO_MIX = 2'h1,
		ADR_TOPO_485 = 2'h2
	} adr_topo_t;

	typedef struct packed {
		logic [23:0] single_turn;
		logic [15:0] multi_turn;
		logic [7:0] stat_l;
		logic [7:0] stat_h;
	} adr_rec_t;

	typedef struct packed {
		logic port_485;
		logic [3:0] axis;
		logic [3:0] cmd;
	} adr_req_t;
endpackage : adr_pkg

// File: core/adr_readout.sv
// Absolute record builder, axis addressing, battery alarm clear and byte FIFO
// Operation
// - Report absolute position as single-turn angle plus multi-turn count.
// - Multi-turn count holds whole revolutions since the last encoder clear.
// - Both values travel in a 15-byte binary record on either port.
// - Each low status flag reads 1 on its error, 0 otherwise.
// - Summary error set on battery, multi-turn, overflow, counter or full-abs error.
// - Alarm clear input held to common return over 120 ms clears battery alarm.
// - Console alarm clear function also clears the battery alarm.
// - Up to sixteen drivers share one host, each by its own axis id.
// - Serve parameter, alarm, monitor, absolute read and save/load requests.
// - Two ports, three topologies: RS232, RS232 relayed to RS485, RS485.
// - Single RS232 link accepts any axis id from 0 to F.
// - Record valid only when low byte of its 15-byte sum is zero.
// - RS485 recognition byte is axis id in low bits with bit7 set.
// - Servo-ready rises 2 s after power-on; capture only while ready.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module adr_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready = count != (AW+1)'(DEPTH);
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : adr_fifo

////////////////////////////////////////////////////////////////////////////////
module adr_readout import adr_pkg::*; #(
	parameter int unsigned CLR_HOLD = CLR_HOLD_CYC,
	parameter int unsigned READY_DELAY = READY_DELAY_CYC,
	parameter int unsigned FIFO_DEPTH = 32
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// Encoder side
	input wire logic [23:0] SINGLE_TURN,
	input wire logic REV_UP,
	input wire logic REV_DOWN,
	input wire logic ENC_CLEAR,
	input wire logic BATT_LOW,
	input wire logic MT_ERR,
	input wire logic CNT_OVF,
	input wire logic CNT_ERR,
	input wire logic FULL_ABS,
	input wire logic [7:0] STAT_HIGH,
	// Axis setup and motor state
	input wire logic [3:0] AXIS_ID_SWITCH,
	input wire logic [1:0] TOPOLOGY,
	input wire logic SERVO_OFF,
	input wire logic BRAKE_HELD,
	// Alarm clear sources
	input wire logic ALARM_CLEAR_INPUT_N,
	input wire logic CONSOLE_ALARM_CLEAR,
	// Host request
	input wire logic REQ_VALID,
	input wire adr_req_t REQ,
	// Other host commands handed to the command handler
	output logic OTHER_CMD_VALID,
	output logic [3:0] OTHER_CMD,
	// Status
	output logic SERVO_READY,
	output logic BATT_ALARM,
	output logic [7:0] MODULE_RECOG,
	output logic REC_BUSY,
	// Record byte stream
	output logic TX_VALID,
	input wire logic TX_READY,
	output logic [7:0] TX_DATA
);
	typedef enum logic [1:0] {
		S_IDLE = 2'b01,
		S_SEND = 2'b10
	} adr_state_t;

	adr_state_t state;
	logic [3:0] axis_id;
	logic id_caught;
	logic [28:0] ready_cnt;
	logic [24:0] hold_cnt;
	logic hold_clear;
	logic [15:0] multi_turn;
	logic [7:0] stat_l;
	adr_rec_t snap;
	logic [3:0] idx;
	logic [7:0] sum;
	logic [7:0] push_data;
	logic push_ready;
	logic push;
	logic addr_ok;
	logic accept;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	function automatic logic [7:0] rec_byte(adr_rec_t r, logic [3:0] id, logic [3:0] i);
		case (i)
			4'h0: rec_byte = {4'h0, id};
			4'h1: rec_byte = r.single_turn[7:0];
			4'h2: rec_byte = r.single_turn[15:8];
			4'h3: rec_byte = r.single_turn[23:16];
			4'h4: rec_byte = r.multi_turn[7:0];
			4'h5: rec_byte = r.multi_turn[15:8];
			4'h6: rec_byte = r.stat_l;
			4'h7: rec_byte = r.stat_h;
			default: rec_byte = BYTE_ZERO;
		endcase
	endfunction : rec_byte

	// Axis id is taken once after power-on, like a strap
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			id_caught <= 1'b0;
			axis_id <= 4'h0;
		end else if (!id_caught) begin
			id_caught <= 1'b1;
			axis_id <= AXIS_ID_SWITCH;
		end
	end

	assign MODULE_RECOG = {RECOG_HIGH, axis_id};

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			ready_cnt <= '0;
			SERVO_READY <= 1'b0;
		end else if (ready_cnt == 29'(READY_DELAY - 1)) begin
			SERVO_READY <= 1'b1;
		end else begin
			ready_cnt <= ready_cnt + 1'b1;
		end
	end

	// Revolution counter wraps; host applies the signed view
	always_ff @(posedge CORE_CLK) begin
		if (RST || ENC_CLEAR) begin
			multi_turn <= 16'h0000;
		end else if (REV_UP && !REV_DOWN) begin
			multi_turn <= multi_turn + 16'h0001;
		end else if (REV_DOWN && !REV_UP) begin
			multi_turn <= multi_turn - 16'h0001;
		end
	end

	// Clear fires once per hold, so a stuck input cannot mask new alarms
	always_ff @(posedge CORE_CLK) begin
		if (RST || ALARM_CLEAR_INPUT_N) begin
			hold_cnt <= '0;
		end else if (hold_cnt != 25'(CLR_HOLD + 1)) begin
			hold_cnt <= hold_cnt + 1'b1;
		end
	end

	assign hold_clear = hold_cnt == 25'(CLR_HOLD);

	// Set wins over either clear
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			BATT_ALARM <= 1'b0;
		end else if (BATT_LOW) begin
			BATT_ALARM <= 1'b1;
		end else if (hold_clear || CONSOLE_ALARM_CLEAR) begin
			BATT_ALARM <= 1'b0;
		end
	end

	always_comb begin
		stat_l = 8'h00;
		stat_l[STAT_BATT_ALARM] = BATT_ALARM;
		stat_l[STAT_MT_ERR] = MT_ERR;
		stat_l[STAT_OVF] = CNT_OVF;
		stat_l[STAT_CNT_ERR] = CNT_ERR;
		stat_l[STAT_FULL_ABS] = FULL_ABS;
		stat_l[STAT_SUMMARY] = BATT_ALARM | MT_ERR | CNT_OVF | CNT_ERR | FULL_ABS;
	end

	// Id 0 belongs to the host side on RS485, so it never answers there
	always_comb begin
		if (REQ.port_485) begin
			addr_ok = (TOPOLOGY != ADR_TOPO_232) && (axis_id != AXIS_HOST)
				&& (REQ.axis == axis_id);
		end else if (TOPOLOGY == ADR_TOPO_485) begin
			addr_ok = 1'b0;
		end else begin
			addr_ok = REQ.axis == axis_id;
		end
	end

	assign accept = REQ_VALID && addr_ok && (state == S_IDLE);

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			OTHER_CMD_VALID <= 1'b0;
			OTHER_CMD <= 4'h0;
		end else begin
			OTHER_CMD_VALID <= accept && (REQ.cmd != CMD_ABS_READ);
			OTHER_CMD <= REQ.cmd;
		end
	end

	assign push_data = (idx == IDX_LAST) ? 8'(~sum + 8'h01) : rec_byte(snap, axis_id, idx);
	assign push = (state == S_SEND) && push_ready;
	assign REC_BUSY = state == S_SEND;

	// Capture only while ready and parked, as the record must be stable
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state <= S_IDLE;
			snap <= '0;
			idx <= IDX_FIRST;
			sum <= 8'h00;
		end else begin
			case (state)
				S_IDLE: begin
					if (accept && REQ.cmd == CMD_ABS_READ && SERVO_READY && SERVO_OFF
						&& BRAKE_HELD) begin
						snap <= '{single_turn: SINGLE_TURN, multi_turn: multi_turn,
							stat_l: stat_l, stat_h: STAT_HIGH};
						idx <= IDX_FIRST;
						sum <= 8'h00;
						state <= S_SEND;
					end
				end
				S_SEND: begin
					if (push) begin
						sum <= sum + push_data;
						idx <= idx + 4'h1;
						if (idx == IDX_LAST) begin
							state <= S_IDLE;
						end
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	adr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(CORE_CLK),
		.rst(RST),
		.in_valid(push),
		.in_ready(push_ready),
		.in_data(push_data),
		.out_valid(TX_VALID),
		.out_ready(TX_READY),
		.out_data(TX_DATA)
	);

	////////////////////////////////////////////////////////////////////////////
	property p_checksum;
		push && idx == IDX_LAST |-> 8'(sum + push_data) == 8'h00;
	endproperty
	a_checksum: assert property (p_checksum) else $error("Record sum not zero");

	property p_rec_len;
		push && idx == IDX_LAST |=> state == S_IDLE && !REC_BUSY;
	endproperty
	a_rec_len: assert property (p_rec_len) else $error("Record not ended at 15 bytes");

	property p_snap;
		state == S_IDLE ##1 state == S_SEND |-> snap.single_turn == $past(SINGLE_TURN)
			&& snap.multi_turn == $past(multi_turn);
	endproperty
	a_snap: assert property (p_snap) else $error("Snapshot mismatch");

	property p_enc_clear;
		ENC_CLEAR |=> multi_turn == 16'h0000;
	endproperty
	a_enc_clear: assert property (p_enc_clear) else $error("Count not cleared");

	property p_stat;
		stat_l[7:6] == 2'b00 && stat_l[STAT_MT_ERR] == MT_ERR && stat_l[STAT_OVF] == CNT_OVF;
	endproperty
	a_stat: assert property (p_stat) else $error("Status flag wrong");

	property p_summary;
		stat_l[STAT_SUMMARY] == |stat_l[STAT_FULL_ABS:STAT_BATT_ALARM];
	endproperty
	a_summary: assert property (p_summary) else $error("Summary wrong");

	property p_hold_clear;
		hold_clear && !BATT_LOW |=> !BATT_ALARM;
	endproperty
	a_hold_clear: assert property (p_hold_clear) else $error("Held clear ignored");

	property p_early;
		!ALARM_CLEAR_INPUT_N ##1 !ALARM_CLEAR_INPUT_N |-> hold_cnt != '0;
	endproperty
	a_early: assert property (p_early) else $error("Hold not counted");

	property p_console;
		CONSOLE_ALARM_CLEAR && !BATT_LOW |=> !BATT_ALARM;
	endproperty
	a_console: assert property (p_console) else $error("Console clear ignored");

	property p_id0_485;
		REQ_VALID && REQ.port_485 && axis_id == AXIS_HOST |-> !accept;
	endproperty
	a_id0_485: assert property (p_id0_485) else $error("Id 0 answered on RS485");

	property p_232_any;
		REQ_VALID && !REQ.port_485 && TOPOLOGY == ADR_TOPO_232 && REQ.axis == axis_id
			&& state == S_IDLE |-> accept;
	endproperty
	a_232_any: assert property (p_232_any) else $error("RS232 id refused");

	property p_recog;
		MODULE_RECOG[7] && MODULE_RECOG[6:4] == 3'b000 && MODULE_RECOG[3:0] == axis_id;
	endproperty
	a_recog: assert property (p_recog) else $error("Recognition byte wrong");

	property p_not_ready;
		!SERVO_READY && state == S_IDLE |=> state == S_IDLE;
	endproperty
	a_not_ready: assert property (p_not_ready) else $error("Capture before ready");

	property p_other;
		accept && REQ.cmd != CMD_ABS_READ |=> OTHER_CMD_VALID && state == S_IDLE;
	endproperty
	a_other: assert property (p_other) else $error("Command not handed on");

	property p_id_const;
		id_caught |=> axis_id == $past(axis_id);
	endproperty
	a_id_const: assert property (p_id_const) else $error("Axis id changed");

	c_record: cover property (push && idx == IDX_LAST);
	c_hold_clear: cover property (hold_clear && BATT_ALARM);
	c_485_accept: cover property (accept && REQ.port_485);
	c_fifo_stall: cover property (REC_BUSY && !push_ready);
endmodule : adr_readout

// File: verif/adr_host_model.sv
// Host side of the record byte stream: drains and keeps the bytes
`timescale 1ns/1ps
module adr_host_model (
	// Clock
	input wire logic clk,
	// Stream from the device
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	// Bench control
	input wire logic stall
);
	logic [7:0] got[$];
	// A stalled host holds ready low, like a busy receiver
	assign tx_ready = !stall;
	always @(posedge clk) begin
		if (tx_valid && tx_ready) begin
			got.push_back(tx_data);
		end
	end
endmodule : adr_host_model

// File: verif/tb_adr_readout.sv
// Self-checking bench for the absolute data readout block
`timescale 1ns/1ps
module tb_adr_readout import adr_pkg::*;;
	localparam int unsigned HOLD = 20;
	localparam int unsigned RDY = 50;
	localparam logic [3:0] ID = 4'h5;
	// Axis switching gap, scaled down like the other times
	localparam int unsigned GAP = 10;
	logic [3:0] sw = ID;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [23:0] st = 24'hA5C3E1;
	logic up = 1'b0, dn = 1'b0, eclr = 1'b0, blow = 1'b0;
	logic mte = 1'b0, ovf = 1'b0, cerr = 1'b0, fabs = 1'b0;
	logic [7:0] sth = 8'h3C;
	logic [1:0] topo = 2'h1;
	logic soff = 1'b1, brk = 1'b1, clr_n = 1'b1, cclr = 1'b0, rv = 1'b0, stall = 1'b1;
	adr_req_t rq = 9'h000;
	logic ocv, rdy, balm, busy, txv, txr;
	logic [3:0] ocmd;
	logic [7:0] recog, txd;
	logic [7:0] exp[15];
	int fails = 0, checked = 0, cyc = 0;

	always #2 clk = ~clk;

	adr_readout #(.CLR_HOLD(HOLD), .READY_DELAY(RDY), .FIFO_DEPTH(32)) adr_readout_i (
		.CORE_CLK(clk), .RST(rst), .SINGLE_TURN(st), .REV_UP(up), .REV_DOWN(dn),
		.ENC_CLEAR(eclr), .BATT_LOW(blow), .MT_ERR(mte), .CNT_OVF(ovf), .CNT_ERR(cerr),
		.FULL_ABS(fabs), .STAT_HIGH(sth), .AXIS_ID_SWITCH(sw), .TOPOLOGY(topo),
		.SERVO_OFF(soff), .BRAKE_HELD(brk), .ALARM_CLEAR_INPUT_N(clr_n),
		.CONSOLE_ALARM_CLEAR(cclr), .REQ_VALID(rv), .REQ(rq), .OTHER_CMD_VALID(ocv),
		.OTHER_CMD(ocmd), .SERVO_READY(rdy), .BATT_ALARM(balm), .MODULE_RECOG(recog),
		.REC_BUSY(busy), .TX_VALID(txv), .TX_READY(txr), .TX_DATA(txd));

	adr_host_model adr_host_model_i (
		.clk(clk), .tx_valid(txv), .tx_ready(txr), .tx_data(txd), .stall(stall));

	////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize

	// Guard against a hang anywhere in the sequence
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			summarize();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
		checked++;
		if (seen !== want) begin
			fails++;
			$display("BAD %0t %s: got %0h want %0h", $time, what, seen, want);
		end
	endtask : chk

	task automatic cyc_n(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc_n

	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc_n(1);
		s = 1'b0;
		cyc_n(1);
	endtask : pulse

	// Ends on the negedge after the taking edge, where one-cycle answers stand
	task automatic send(input logic p, input logic [3:0] ax, input logic [3:0] cmd);
		rv = 1'b1;
		rq = {p, ax, cmd};
		cyc_n(1);
		rv = 1'b0;
	endtask : send

	task automatic other(input logic p, input logic [3:0] cmd, input logic want);
		send(p, ID, cmd);
		chk(ocv, want, "other command strobe");
		if (want) begin
			chk(ocmd, cmd, "other command code");
		end
		cyc_n(1);
		chk(ocv, 1'b0, "strobe lasts one cycle");
	endtask : other

	task automatic wait_idle();
		for (int i = 0; i < 200 && busy !== 1'b0; i++) cyc_n(1);
		chk(busy, 1'b0, "record push finished");
	endtask : wait_idle

	task automatic mk(input logic [15:0] mt, input logic [7:0] sl);
		logic [7:0] s;
		s = 8'h00;
		exp = '{default: 8'h00};
		exp[0] = {4'h0, ID};
		exp[1] = st[7:0];
		exp[2] = st[15:8];
		exp[3] = st[23:16];
		exp[4] = mt[7:0];
		exp[5] = mt[15:8];
		exp[6] = sl;
		exp[7] = sth;
		for (int i = 0; i < 14; i++) s += exp[i];
		exp[14] = 8'h00 - s;
	endtask : mk

	task automatic cmp(input int n);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 300 && adr_host_model_i.got.size() < n; i++) cyc_n(1);
		chk(adr_host_model_i.got.size(), n, "byte count");
		for (int i = 0; i < n; i++) begin
			chk(adr_host_model_i.got[i], exp[i % 15], "record byte");
			s += adr_host_model_i.got[i];
		end
		chk(s, 8'h00, "record sum");
		adr_host_model_i.got.delete();
	endtask : cmp

	////////////////////////////////////////////////////////////////////////////
	task automatic t_ready();
		cyc_n(2);
		chk(recog, {4'h8, ID}, "recognition byte");
		send(1'b0, ID, CMD_ABS_READ);
		chk(busy, 1'b0, "read refused before ready");
		cyc_n(RDY - 4);
		chk(rdy, 1'b0, "ready too early");
		cyc_n(1);
		chk(rdy, 1'b1, "ready on time");
	endtask : t_ready

	// Three records against a stalled host fill the 32-byte buffer and hold the third record's push
	task automatic t_fill();
		repeat (3) pulse(up);
		up = 1'b1;
		dn = 1'b1;
		cyc_n(1);
		up = 1'b0;
		dn = 1'b0;
		pulse(blow);
		mte = 1'b1;
		mk(16'h0003, 8'h23);
		send(1'b0, ID, CMD_ABS_READ);
		chk(busy, 1'b1, "record started");
		wait_idle();
		send(1'b0, ID, CMD_ABS_READ);
		wait_idle();
		send(1'b0, ID, CMD_ABS_READ);
		cyc_n(40);
		chk(busy, 1'b1, "push held while full");
		chk(txv, 1'b1, "bytes pending");
		stall = 1'b0;
		cmp(45);
		chk(txv, 1'b0, "buffer drained");
		mte = 1'b0;
	endtask : t_fill

	task automatic t_neg();
		int turns;
		pulse(eclr);
		pulse(dn);
		pulse(dn);
		ovf = 1'b1;
		cerr = 1'b1;
		fabs = 1'b1;
		mk(16'hFFFE, 8'h3D);
		send(1'b0, ID, CMD_ABS_READ);
		wait_idle();
		// Host view of the raw count: upper half means negative
		turns = {adr_host_model_i.got[5], adr_host_model_i.got[4]};
		if (turns >= 32768) begin
			turns -= 65536;
		end
		chk(turns, -2, "signed turn count");
		cmp(15);
		ovf = 1'b0;
		cerr = 1'b0;
		fabs = 1'b0;
	endtask : t_neg

	task automatic t_addr();
		cyc_n(GAP);
		send(1'b0, 4'h6, CMD_ABS_READ);
		chk(busy, 1'b0, "other axis ignored");
		cyc_n(GAP);
		other(1'b1, 4'h3, 1'b1);
		topo = 2'h0;
		other(1'b1, 4'h3, 1'b0);
		other(1'b0, 4'h7, 1'b1);
		topo = 2'h2;
		other(1'b0, 4'h3, 1'b0);
		other(1'b1, 4'h7, 1'b1);
		soff = 1'b0;
		send(1'b1, ID, CMD_ABS_READ);
		chk(busy, 1'b0, "read refused with servo on");
		soff = 1'b1;
		brk = 1'b0;
		cyc_n(1);
		send(1'b1, ID, CMD_ABS_READ);
		chk(busy, 1'b0, "read refused with brake off");
		brk = 1'b1;
		topo = 2'h1;
		cyc_n(1);
	endtask : t_addr

	task automatic t_clear();
		chk(balm, 1'b1, "alarm latched");
		clr_n = 1'b0;
		cyc_n(HOLD - 2);
		clr_n = 1'b1;
		cyc_n(1);
		chk(balm, 1'b1, "short hold keeps alarm");
		clr_n = 1'b0;
		cyc_n(HOLD + 3);
		chk(balm, 1'b0, "long hold clears alarm");
		clr_n = 1'b1;
		pulse(blow);
		chk(balm, 1'b1, "alarm set again");
		cclr = 1'b1;
		cyc_n(1);
		cclr = 1'b0;
		chk(balm, 1'b0, "console clear");
		cyc_n(1);
	endtask : t_clear

	// Second reset with the switch at 0: host-side driver of the mixed topology
	task automatic t_id0();
		sw = 4'h0;
		rst = 1'b1;
		cyc_n(3);
		rst = 1'b0;
		cyc_n(2);
		chk(recog, 8'h80, "recognition byte id 0");
		chk(rdy, 1'b0, "ready low after reset");
		chk(txv, 1'b0, "buffer empty after reset");
		send(1'b1, 4'h0, 4'h3);
		chk(ocv, 1'b0, "id 0 silent on RS485");
		cyc_n(1);
		send(1'b0, 4'h0, 4'h4);
		chk(ocv, 1'b1, "id 0 answers on RS232");
		chk(ocmd, 4'h4, "id 0 command code");
		cyc_n(1);
	endtask : t_id0

	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		t_ready();
		t_fill();
		t_neg();
		t_addr();
		t_clear();
		t_id0();
		summarize();
	end
endmodule : tb_adr_readout
